// ### logic/gdcfg_defs.svh
// Register offsets, field positions and reset values for the gate drive config bank
`ifndef GDCFG_DEFS_SVH
`define GDCFG_DEFS_SVH
`define GDCFG_ADDR_SHUTDOWN    8'h21
`define GDCFG_ADDR_PREDIS      8'h22
`define GDCFG_ADDR_PWMOPT      8'h23
`define GDCFG_RST_SHUTDOWN     16'h0700
`define GDCFG_RST_PREDIS       16'h0000
`define GDCFG_RST_PWMOPT       16'h0000
`define GDCFG_MASK_SHUTDOWN    16'h0f3f
`define GDCFG_MASK_PREDIS      16'h3f3f
`define GDCFG_MASK_PWMOPT      16'hf33f
`define GDCFG_SDT_MSB          11
`define GDCFG_SDT_LSB          8
`define GDCFG_SDI_MSB          5
`define GDCFG_HPD_MSB          13
`define GDCFG_HPD_LSB          8
`define GDCFG_LPD_MSB          5
`define GDCFG_RECT_BIT         15
`define GDCFG_DIR_BIT          14
`define GDCFG_OCFG_MSB         13
`define GDCFG_OCFG_LSB         12
`define GDCFG_SRCCFG_BIT       9
`define GDCFG_HOLD_BIT         8
`define GDCFG_DHA_BIT          5
`define GDCFG_DHB_BIT          4
`define GDCFG_DHC_BIT          3
`define GDCFG_DLA_BIT          2
`define GDCFG_DLB_BIT          1
`define GDCFG_DLC_BIT          0
`define GDCFG_PWM_SPI_MODE     3'h5
`define GDCFG_RATIO_TOP_CODE   6'h23
`define GDCFG_SAME_LOW_CODE    6'h24
`define GDCFG_SAME_TOP_CODE    6'h2c
`endif

// ### logic/gdcfg_pkg.sv
// Types shared by the gate drive configuration bank
`default_nettype none
package gdcfg_pkg;
    typedef enum logic [1:0] {
        GDCFG_OUT_FOLLOW,
        GDCFG_OUT_ALL_LOW,
        GDCFG_OUT_ALL_HIGH,
        GDCFG_OUT_COAST
    } gdcfg_ocfg_e;
    typedef enum logic [1:0] {
        GDCFG_SRC_RATIO,
        GDCFG_SRC_SAME_CODE,
        GDCFG_SRC_DIRECT
    } gdcfg_src_e;
endpackage : gdcfg_pkg
`default_nettype wire

// ### logic/gdcfg_regs.sv
// Gate drive configuration registers and the gate control they steer
`include "gdcfg_defs.svh"
`default_nettype none

module gdcfg_regs
    import gdcfg_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // Register port from the serial interface
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    output logic             o_rd_hit,
    // Neighbouring control state
    input  wire logic        i_driver_enable_bit,
    input  wire logic [2:0]  i_pwm_mode,
    input  wire logic        i_phase_c_high_input,
    input  wire logic        i_single_input_mode,
    input  wire logic [5:0]  i_peak_sink_current,
    input  wire logic [5:0]  i_direct_source_current,
    input  wire logic [1:0]  i_source_sink_ratio,
    // Configuration out to the analog drivers
    output logic      [3:0]  o_shutdown_discharge_time,
    output logic      [5:0]  o_shutdown_sink_current,
    output logic      [5:0]  o_high_side_predischarge_current,
    output logic      [5:0]  o_low_side_predischarge_current,
    output logic             o_async_rectification,
    output logic             o_direction,
    output gdcfg_ocfg_e      o_single_input_output_config,
    output gdcfg_src_e       o_source_select,
    output logic      [5:0]  o_peak_source_current_code,
    output logic      [1:0]  o_ratio_used,
    output logic             o_hold_current_select,
    output logic             o_hold_change_violation,
    // Direct gate drive, high and low sides ordered A, B, C as bits 2..0
    output logic             o_direct_drive_active,
    output logic      [2:0]  o_direct_high,
    output logic      [2:0]  o_direct_low
);

    logic [15:0] shutdown_discharge_ctrl;
    logic [15:0] predischarge_current_ctrl;
    logic [15:0] pwm_option_direct_drive_ctrl;
    logic [15:0] next_shutdown;
    logic [15:0] next_predis;
    logic [15:0] next_pwmopt;
    logic [15:0] next_rdata;
    logic        next_rd_hit;
    logic        next_violation;
    logic        direct_mode;
    logic        sync_pin_a;
    logic        sync_pin_b;

    // Merge a write into a register, keeping reserved bits at zero
    function automatic logic [15:0] gdcfg_merge(input logic [15:0] wdata,
                                                input logic [15:0] mask);
        gdcfg_merge = wdata & mask;
    endfunction : gdcfg_merge

    // Register writes; reserved bits never store
    always_comb begin
        next_shutdown = shutdown_discharge_ctrl;
        next_predis   = predischarge_current_ctrl;
        next_pwmopt   = pwm_option_direct_drive_ctrl;
        next_violation = 1'b0;
        if (i_wr_en) begin
            unique case (i_addr)
                `GDCFG_ADDR_SHUTDOWN: begin
                    next_shutdown = gdcfg_merge(i_wdata, `GDCFG_MASK_SHUTDOWN);
                end
                `GDCFG_ADDR_PREDIS: begin
                    next_predis = gdcfg_merge(i_wdata, `GDCFG_MASK_PREDIS);
                end
                `GDCFG_ADDR_PWMOPT: begin
                    next_pwmopt = gdcfg_merge(i_wdata, `GDCFG_MASK_PWMOPT);
                    // Flag a hold select change made while driving; it still stores
                    next_violation = i_driver_enable_bit &&
                        (i_wdata[`GDCFG_HOLD_BIT] !=
                         pwm_option_direct_drive_ctrl[`GDCFG_HOLD_BIT]);
                end
                default: begin
                end
            endcase
        end
    end

    // Register storage with documented reset values
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shutdown_discharge_ctrl      <= `GDCFG_RST_SHUTDOWN;
            predischarge_current_ctrl    <= `GDCFG_RST_PREDIS;
            pwm_option_direct_drive_ctrl <= `GDCFG_RST_PWMOPT;
            o_hold_change_violation      <= 1'b0;
        end else begin
            shutdown_discharge_ctrl      <= next_shutdown;
            predischarge_current_ctrl    <= next_predis;
            pwm_option_direct_drive_ctrl <= next_pwmopt;
            o_hold_change_violation      <= next_violation;
        end
    end

    // Read mux; unmapped addresses read zero and report no hit
    always_comb begin
        next_rdata  = 16'h0000;
        next_rd_hit = 1'b0;
        if (i_rd_en) begin
            unique case (i_addr)
                `GDCFG_ADDR_SHUTDOWN: begin
                    next_rdata  = shutdown_discharge_ctrl;
                    next_rd_hit = 1'b1;
                end
                `GDCFG_ADDR_PREDIS: begin
                    next_rdata  = predischarge_current_ctrl;
                    next_rd_hit = 1'b1;
                end
                `GDCFG_ADDR_PWMOPT: begin
                    next_rdata  = pwm_option_direct_drive_ctrl;
                    next_rd_hit = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rdata  <= 16'h0000;
            o_rd_hit <= 1'b0;
        end else begin
            o_rdata  <= next_rdata;
            o_rd_hit <= next_rd_hit;
        end
    end

    // Phase-C pin is asynchronous to this clock, so two flops first
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sync_pin_a <= 1'b0;
            sync_pin_b <= 1'b0;
        end else begin
            sync_pin_a <= i_phase_c_high_input;
            sync_pin_b <= sync_pin_a;
        end
    end

    // Field outputs straight from the stored registers
    assign o_shutdown_discharge_time =
        shutdown_discharge_ctrl[`GDCFG_SDT_MSB:`GDCFG_SDT_LSB];
    assign o_shutdown_sink_current =
        shutdown_discharge_ctrl[`GDCFG_SDI_MSB:0];
    assign o_high_side_predischarge_current =
        predischarge_current_ctrl[`GDCFG_HPD_MSB:`GDCFG_HPD_LSB];
    assign o_low_side_predischarge_current =
        predischarge_current_ctrl[`GDCFG_LPD_MSB:0];
    assign o_hold_current_select =
        pwm_option_direct_drive_ctrl[`GDCFG_HOLD_BIT];

    // Single-input options apply only in that mode; outside it they read neutral
    assign o_async_rectification = i_single_input_mode &&
        pwm_option_direct_drive_ctrl[`GDCFG_RECT_BIT];
    assign o_direction = i_single_input_mode &&
        (pwm_option_direct_drive_ctrl[`GDCFG_DIR_BIT] || sync_pin_b);
    assign o_single_input_output_config = i_single_input_mode ?
        gdcfg_ocfg_e'(pwm_option_direct_drive_ctrl[`GDCFG_OCFG_MSB:`GDCFG_OCFG_LSB]) :
        GDCFG_OUT_FOLLOW;

    // Source current selection; codes past the top legal code fall back to ratio
    always_comb begin
        o_source_select            = GDCFG_SRC_RATIO;
        o_peak_source_current_code = i_peak_sink_current;
        o_ratio_used               = i_source_sink_ratio;
        if (pwm_option_direct_drive_ctrl[`GDCFG_SRCCFG_BIT]) begin
            o_source_select            = GDCFG_SRC_DIRECT;
            o_peak_source_current_code = i_direct_source_current;
            o_ratio_used               = 2'h0;
        end else if (i_peak_sink_current > `GDCFG_RATIO_TOP_CODE &&
                     i_peak_sink_current <= `GDCFG_SAME_TOP_CODE) begin
            o_source_select = GDCFG_SRC_SAME_CODE;
            o_ratio_used    = 2'h0;
        end else begin
            o_source_select = GDCFG_SRC_RATIO;
        end
    end

    // Direct gate drive only in SPI drive mode with the driver on; else all low
    assign direct_mode = i_driver_enable_bit && (i_pwm_mode == `GDCFG_PWM_SPI_MODE);
    assign o_direct_drive_active = direct_mode;
    assign o_direct_high = direct_mode ? {
        pwm_option_direct_drive_ctrl[`GDCFG_DHA_BIT],
        pwm_option_direct_drive_ctrl[`GDCFG_DHB_BIT],
        pwm_option_direct_drive_ctrl[`GDCFG_DHC_BIT]} : 3'h0;
    assign o_direct_low = direct_mode ? {
        pwm_option_direct_drive_ctrl[`GDCFG_DLA_BIT],
        pwm_option_direct_drive_ctrl[`GDCFG_DLB_BIT],
        pwm_option_direct_drive_ctrl[`GDCFG_DLC_BIT]} : 3'h0;

    // Shutdown register resets to timing code 0111b and current zero
    property p_shutdown_reset;
        @(posedge i_ref_clk) disable iff (i_rst)
        $past(i_rst) |-> ({4'h0, o_shutdown_discharge_time, 2'h0, o_shutdown_sink_current} ==
            `GDCFG_RST_SHUTDOWN);
    endproperty
    a_shutdown_reset: assert property (p_shutdown_reset)
        else $error("shutdown reset wrong");

    // A shutdown write shows its current code one cycle later
    property p_sink_write;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_wr_en && i_addr == `GDCFG_ADDR_SHUTDOWN) |=> (o_shutdown_sink_current ==
            $past(i_wdata[`GDCFG_SDI_MSB:0]));
    endproperty
    a_sink_write: assert property (p_sink_write)
        else $error("sink current not stored");

    // Both predischarge fields land one cycle after their write
    property p_predis_write;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_wr_en && i_addr == `GDCFG_ADDR_PREDIS) |=>
            (o_high_side_predischarge_current ==
                 $past(i_wdata[`GDCFG_HPD_MSB:`GDCFG_HPD_LSB]) &&
             o_low_side_predischarge_current == $past(i_wdata[`GDCFG_LPD_MSB:0]));
    endproperty
    a_predis_write: assert property (p_predis_write)
        else $error("predischarge not stored");

    // Asynchronous rectification exactly when bit 15 is set in single-input mode
    property p_rect;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_async_rectification ==
            (i_single_input_mode && pwm_option_direct_drive_ctrl[`GDCFG_RECT_BIT]);
    endproperty
    a_rect: assert property (p_rect)
        else $error("rectification wrong");

    // Pin reaches the direction two flops late; edges touched by reset are skipped
    property p_dir;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_single_input_mode && $past(i_phase_c_high_input, 2) &&
         !$past(i_rst) && !$past(i_rst, 2)) |-> o_direction;
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction missed pin");

    // Outside single-input mode the output config reads neutral
    property p_ocfg;
        @(posedge i_ref_clk) disable iff (i_rst)
        !i_single_input_mode |-> (o_single_input_output_config == GDCFG_OUT_FOLLOW);
    endproperty
    a_ocfg: assert property (p_ocfg)
        else $error("output config not neutral");

    // Low sink codes derive the source current from the ratio
    property p_ratio;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!pwm_option_direct_drive_ctrl[`GDCFG_SRCCFG_BIT] &&
         i_peak_sink_current <= `GDCFG_RATIO_TOP_CODE) |->
            (o_source_select == GDCFG_SRC_RATIO && o_ratio_used == i_source_sink_ratio);
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("ratio source wrong");

    // High sink codes reuse the sink code as source code
    property p_same_code;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!pwm_option_direct_drive_ctrl[`GDCFG_SRCCFG_BIT] &&
         i_peak_sink_current >= `GDCFG_SAME_LOW_CODE &&
         i_peak_sink_current <= `GDCFG_SAME_TOP_CODE) |->
            (o_source_select == GDCFG_SRC_SAME_CODE &&
             o_peak_source_current_code == i_peak_sink_current);
    endproperty
    a_same_code: assert property (p_same_code)
        else $error("same-code source wrong");

    // Config bit 9 hands the source current to the direct fields
    property p_direct_src;
        @(posedge i_ref_clk) disable iff (i_rst)
        pwm_option_direct_drive_ctrl[`GDCFG_SRCCFG_BIT] |->
            (o_source_select == GDCFG_SRC_DIRECT &&
             o_peak_source_current_code == i_direct_source_current);
    endproperty
    a_direct_src: assert property (p_direct_src)
        else $error("direct source wrong");

    // Direct drive bits reach the gates the cycle after their write
    property p_spi_drive;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_wr_en && i_addr == `GDCFG_ADDR_PWMOPT) ##1 (i_driver_enable_bit &&
            i_pwm_mode == `GDCFG_PWM_SPI_MODE) |->
            (o_direct_high == $past(i_wdata[`GDCFG_DHA_BIT:`GDCFG_DHC_BIT]) &&
             o_direct_low == $past(i_wdata[`GDCFG_DLA_BIT:`GDCFG_DLC_BIT]));
    endproperty
    a_spi_drive: assert property (p_spi_drive)
        else $error("direct drive wrong");

    // Every reserved bit of the option register reads back zero
    property p_reserved;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_rd_en && i_addr == `GDCFG_ADDR_PWMOPT) |=>
            ((o_rdata & ~`GDCFG_MASK_PWMOPT) == 16'h0000);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits nonzero");

endmodule : gdcfg_regs
`default_nettype wire

// ### sim/gdcfg_host.sv
// Host model that issues register writes and reads to the configuration bank
`default_nettype none
module gdcfg_host (
    // Clock
    input  wire logic        i_ref_clk,
    // Register requests and answers
    output logic             o_wr_en,
    output logic             o_rd_en,
    output logic      [7:0]  o_addr,
    output logic      [15:0] o_wdata,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rd_hit
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle port at time zero so no strobe floats
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 16'h0000;
    end

    // One write; an idle edge follows so a strobe is never set twice at once
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        o_addr  <= a;
        o_wdata <= d;
        o_wr_en <= 1'b1;
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
        o_addr  <= ~a;    // Stale lines show garbage once taken
        o_wdata <= ~d;
        @(posedge i_ref_clk);
    endtask : wr

    // One read; the answer stands only in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
        o_addr  <= a;
        o_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        #1;
        d = i_rdata;
        h = i_rd_hit;
        @(posedge i_ref_clk);
    endtask : rd
endmodule : gdcfg_host
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the gate drive configuration bank
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk, i_rst, i_wr_en, i_rd_en, o_rd_hit;
    logic [7:0]  i_addr;
    logic [15:0] i_wdata, o_rdata;
    logic        i_driver_enable_bit, i_phase_c_high_input, i_single_input_mode;
    logic [2:0]  i_pwm_mode, o_direct_high, o_direct_low;
    logic [5:0]  i_peak_sink_current, i_direct_source_current, o_shutdown_sink_current;
    logic [5:0]  o_high_side_predischarge_current, o_low_side_predischarge_current;
    logic [5:0]  o_peak_source_current_code;
    logic [3:0]  o_shutdown_discharge_time;
    logic [1:0]  i_source_sink_ratio, o_ratio_used;
    logic        o_async_rectification, o_direction, o_hold_current_select;
    logic        o_hold_change_violation, o_direct_drive_active;
    gdcfg_pkg::gdcfg_ocfg_e o_single_input_output_config;
    gdcfg_pkg::gdcfg_src_e  o_source_select;
    logic [15:0] mreg [3];
    logic [15:0] msk  [3] = '{16'h0f3f, 16'h3f3f, 16'hf33f};
    int          miscompares = 0, n_compared = 0, n_viol = 0, exp_viol = 0, cyc = 0;

    gdcfg_regs dut_u (
        .i_ref_clk, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_rd_hit,
        .i_driver_enable_bit, .i_pwm_mode, .i_phase_c_high_input, .i_single_input_mode,
        .i_peak_sink_current, .i_direct_source_current, .i_source_sink_ratio,
        .o_shutdown_discharge_time, .o_shutdown_sink_current,
        .o_high_side_predischarge_current, .o_low_side_predischarge_current,
        .o_async_rectification, .o_direction, .o_single_input_output_config,
        .o_source_select, .o_peak_source_current_code, .o_ratio_used,
        .o_hold_current_select, .o_hold_change_violation,
        .o_direct_drive_active, .o_direct_high, .o_direct_low
    );
    gdcfg_host host_u (
        .i_ref_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
        .o_wdata(i_wdata), .i_rdata(o_rdata), .i_rd_hit(o_rd_hit)
    );

    // Free-running 100 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // Flag pulses are counted per edge; the cycle count cuts a hang short
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (o_hold_change_violation === 1'b1)
            n_viol = n_viol + 1;
        if (cyc == 12000) begin
            miscompares = miscompares + 1;
            close_out;
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Read through the host and compare with the model; unmapped reads give zero
    task automatic rdchk(input logic [7:0] a);
        logic [15:0] d;
        logic        h;
        int          i;
        i = a - 8'h21;
        host_u.rd(a, d, h);
        chk("rdata", d, (i >= 0 && i < 3) ? mreg[i] : 16'h0000);
        chk("rd_hit", h, 16'(i >= 0 && i < 3));
    endtask : rdchk

    // Write through the host; the model drops reserved bits
    task automatic wrm(input logic [7:0] a, input logic [15:0] d);
        int i;
        i = a - 8'h21;
        if (i == 2 && d[8] != mreg[2][8] && i_driver_enable_bit)
            exp_viol++;
        if (i >= 0 && i < 3)
            mreg[i] = d & msk[i];
        host_u.wr(a, d);
    endtask : wrm

    // Random neighbour state; spi forces driver enabled in SPI gate-drive mode
    task automatic rnd_in(input bit spi);
        logic [19:0] r;
        r = 20'($urandom);
        if (spi)
            r[19:16] = 4'hd;
        {i_driver_enable_bit, i_pwm_mode, i_phase_c_high_input, i_single_input_mode,
         i_peak_sink_current, i_direct_source_current, i_source_sink_ratio} <= r;
        @(posedge i_ref_clk);
    endtask : rnd_in

    // Wait out the pin synchroniser, then compare every field output
    task automatic settle;
        logic [1:0] s;
        logic       m;
        repeat (3) @(posedge i_ref_clk);
        #1;
        m = i_single_input_mode;
        s = mreg[2][9] ? 2'd2 : (i_peak_sink_current inside {[6'h24:6'h2c]}) ? 2'd1 : 2'd0;
        chk("sd_time", o_shutdown_discharge_time, mreg[0][11:8]);
        chk("sd_sink", o_shutdown_sink_current, mreg[0][5:0]);
        chk("hs_pre", o_high_side_predischarge_current, mreg[1][13:8]);
        chk("ls_pre", o_low_side_predischarge_current, mreg[1][5:0]);
        chk("async", o_async_rectification, m & mreg[2][15]);
        chk("dir", o_direction, m & (mreg[2][14] | i_phase_c_high_input));
        chk("ocfg", o_single_input_output_config, m ? mreg[2][13:12] : 2'b00);
        chk("src_sel", o_source_select, s);
        chk("src_code", o_peak_source_current_code,
            mreg[2][9] ? i_direct_source_current : i_peak_sink_current);
        chk("ratio", o_ratio_used, s == 2'd0 ? i_source_sink_ratio : 2'b00);
        chk("hold", o_hold_current_select, mreg[2][8]);
        m = i_driver_enable_bit && i_pwm_mode == 3'h5;
        chk("spi_act", o_direct_drive_active, m);
        chk("dhigh", o_direct_high, m ? mreg[2][5:3] : 3'h0);
        chk("dlow", o_direct_low, m ? mreg[2][2:0] : 3'h0);
        @(posedge i_ref_clk);
    endtask : settle

    task automatic do_reset(input int n);
        i_rst <= 1'b1;
        repeat (n) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        mreg = '{16'h0700, 16'h0000, 16'h0000};
        @(posedge i_ref_clk);
        for (int a = 32; a < 37; a++)
            rdchk(8'(a));
        settle;
    endtask : do_reset

    // Main sequence: reset, random traffic, sink code sweep, second reset at the end
    initial begin
        {i_driver_enable_bit, i_pwm_mode, i_phase_c_high_input, i_single_input_mode,
         i_peak_sink_current, i_direct_source_current, i_source_sink_ratio} = '0;
        i_rst = 1'b1;
        void'($urandom(29746));
        do_reset(6);
        for (int k = 0; k < 200; k++) begin
            rnd_in(k % 3 == 0);
            wrm(8'(32 + $urandom_range(4)), 16'($urandom));
            settle;
            rdchk(8'(33 + $urandom_range(2)));
        end
        for (int p = 0; p < 2; p++) begin
            wrm(8'h23, 16'(p << 9));
            for (int c = 0; c < 64; c++) begin
                i_peak_sink_current <= 6'(c);
                settle;
            end
        end
        do_reset(2);
        chk("hold_flag", 16'(n_viol), 16'(exp_viol));
        close_out;
    end
endmodule : tb_top
`default_nettype wire
